// >>> tb_top.sv
// Self-checking testbench of the receive DMA doorbell notifier.
`timescale 1ns/1ns
`include "touch_rx_dma_regs.svh"
module tb_top;
	localparam logic [63:0] TAIL_AT = 64'hA5A5_0001_1234_5678;
	localparam logic [63:0] BELL_AT = 64'h0000_00C3_8765_432C;
	logic i_clock = 1'b0;
	logic i_nrst = 1'b0;
	touch_rx_dma_pkg::reg_req_s i_reg = '0;
	touch_rx_dma_pkg::frame_char_s i_frame = '0;
	logic i_microframe_start = 1'b0;
	logic i_packet_done = 1'b0;
	logic [15:0] i_packet_bytes = 16'h0000;
	logic i_mem_ready;
	logic slow = 1'b0;
	logic [31:0] o_rdata;
	logic o_rvalid;
	touch_rx_dma_pkg::mem_wr_s o_mem;
	logic [23:0] o_read_address;
	logic o_notify_busy;
	int err_total = 0;
	int comparisons = 0;
	logic [15:0] moff[7] = '{`OFF_TAIL_PTR_LOW, `OFF_TAIL_PTR_HIGH, `OFF_ITEM_SIZE, `OFF_QUEUE_SIZE,
		`OFF_DB_ADDR_LOW, `OFF_DB_ADDR_HIGH, `OFF_TAIL_START};
	logic [31:0] mval[7] = '{32'hFFFFFFF8, 32'hFFFFFFFF, 32'h00FFFFFF, 32'h00FFFFFF, 32'hFFFFFFFC,
		32'hFFFFFFFF, 32'hFFFFFFFF};

	touch_rx_dma_doorbell_notifier dut (
		.i_clock(i_clock),
		.i_nrst(i_nrst),
		.i_reg(i_reg),
		.i_frame(i_frame),
		.i_microframe_start(i_microframe_start),
		.i_packet_done(i_packet_done),
		.i_packet_bytes(i_packet_bytes),
		.i_mem_ready(i_mem_ready),
		.o_rdata(o_rdata),
		.o_rvalid(o_rvalid),
		.o_mem(o_mem),
		.o_read_address(o_read_address),
		.o_notify_busy(o_notify_busy)
	);

	work_queue_memory mem (
		.i_clock(i_clock),
		.i_nrst(i_nrst),
		.i_mem(o_mem),
		.i_slow(slow),
		.o_ready(i_mem_ready)
	);

	// Clock at 25 MHz.
	always #20 i_clock = ~i_clock;

	// ----------------------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------------------
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Inputs always move one nanosecond after the rising edge.
	task automatic tick(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask

	// Each bus task leaves one idle cycle, so no strobe is driven twice in one time step.
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		i_reg = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		tick(1);
		i_reg = '0;
		tick(1);
	endtask

	task automatic rd(input logic [15:0] a, input logic [31:0] exp);
		i_reg = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		tick(1);
		i_reg = '0;
		chk(o_rvalid, 1'b1);
		chk(o_rdata, exp);
		tick(1);
	endtask

	// One frame pulse, then a bounded wait for the sequencer to return to idle.
	task automatic frame(input logic eof, input logic hdr);
		i_frame = '{valid: 1'b1, end_of_frame: eof, frame_header_flag: hdr};
		tick(1);
		i_frame = '0;
		for (int i = 0; i < 40 && o_notify_busy !== 1'b0; i++) tick(1);
		chk(o_notify_busy, 1'b0);
		tick(1);
	endtask

	// The last two logged writes must be the tail write and then the doorbell write.
	task automatic notified(input int n, input logic [31:0] tail, input logic [31:0] bell);
		chk(mem.adr.size(), n);
		chk(mem.adr[n-2], TAIL_AT);
		chk(mem.dat[n-2], tail);
		chk(mem.adr[n-1], BELL_AT);
		chk(mem.dat[n-1], bell);
	endtask

	// ----------------------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------------------
	task automatic t_reset;
		rd(`OFF_TAIL_PTR_LOW, `RST_ZERO);
		rd(`OFF_DB_VALUE, `RST_DB_VALUE);
		rd(`OFF_TAIL_START, `RST_ZERO);
		rd(`OFF_BULK_ADDR, `RST_BULK_ADDR);
		rd(`OFF_DB_COUNT, `RST_ZERO);
		rd(`OFF_FRAME_COUNT, `RST_ZERO);
		rd(16'h1144, `RST_ZERO);
		chk(o_read_address, 24'h001000);
		$display("test reset done");
	endtask

	// Reserved bits must read zero after all ones are written, or all ones except the two reset bits in the control register.
	task automatic t_masks;
		for (int i = 0; i < 7; i++) begin
			wr(moff[i], 32'hFFFFFFFF);
			rd(moff[i], mval[i]);
		end
		wr(`OFF_NOTIFY_CTRL, 32'hFFFFFFEB);
		rd(`OFF_NOTIFY_CTRL, 32'h00000008);
		$display("test masks done");
	endtask

	// Start 0xC0, item 0x40, queue 0x100: the first advance wraps to zero.
	task automatic t_notify;
		wr(`OFF_NOTIFY_CTRL, 32'h0);
		wr(`OFF_TAIL_PTR_LOW, 32'h1234567F);
		wr(`OFF_TAIL_PTR_HIGH, 32'hA5A50001);
		wr(`OFF_DB_ADDR_LOW, 32'h8765432F);
		wr(`OFF_DB_ADDR_HIGH, 32'h000000C3);
		wr(`OFF_ITEM_SIZE, 32'hFF000040);
		wr(`OFF_QUEUE_SIZE, 32'h00000100);
		wr(`OFF_TAIL_START, 32'h000000C0);
		wr(`OFF_DB_VALUE, 32'h00000005);
		frame(1'b1, 1'b0);
		chk(mem.adr.size(), 0);
		wr(`OFF_NOTIFY_CTRL, 32'h00000008);
		slow = 1'b1;
		frame(1'b1, 1'b0);
		notified(2, 32'h0, 32'h5);
		slow = 1'b0;
		frame(1'b1, 1'b1);
		frame(1'b0, 1'b0);
		chk(mem.adr.size(), 2);
		frame(1'b1, 1'b0);
		notified(4, 32'h40, 32'h6);
		rd(`OFF_DB_VALUE, 32'h7);
		rd(`OFF_DB_COUNT, 32'h2);
		rd(`OFF_FRAME_COUNT, 32'h5);
		$display("test notify done");
	endtask

	task automatic t_tail_and_bell;
		wr(`OFF_NOTIFY_CTRL, 32'h00000018);
		rd(`OFF_NOTIFY_CTRL, 32'h00000008);
		frame(1'b1, 1'b0);
		notified(6, 32'h40, 32'h7);
		wr(`OFF_NOTIFY_CTRL, 32'h0);
		wr(`OFF_DB_VALUE, 32'hFFFFFFFF);
		wr(`OFF_NOTIFY_CTRL, 32'h00000008);
		frame(1'b1, 1'b0);
		notified(8, 32'h80, 32'hFFFFFFFF);
		rd(`OFF_DB_VALUE, 32'h1);
		wr(`OFF_NOTIFY_CTRL, 32'h0);
		wr(`OFF_DB_VALUE, 32'h33);
		wr(`OFF_NOTIFY_CTRL, 32'h00000004);
		rd(`OFF_NOTIFY_CTRL, 32'h0);
		rd(`OFF_DB_VALUE, 32'h1);
		$display("test tail and bell done");
	endtask

	task automatic t_counters;
		wr(`OFF_DB_COUNT, 32'h7FFFFFFF);
		rd(`OFF_DB_COUNT, 32'h4);
		wr(`OFF_DB_COUNT, 32'h80000000);
		rd(`OFF_DB_COUNT, 32'h0);
		wr(`OFF_FRAME_COUNT, 32'h80000000);
		rd(`OFF_FRAME_COUNT, 32'h0);
		frame(1'b1, 1'b1);
		rd(`OFF_FRAME_COUNT, 32'h1);
		$display("test counters done");
	endtask

	// Only the low 24 bits of the bulk address reach the read address.
	task automatic t_read_addr;
		wr(`OFF_BULK_ADDR, 32'hAB123456);
		i_microframe_start = 1'b1;
		tick(1);
		i_microframe_start = 1'b0;
		chk(o_read_address, 24'h123456);
		i_packet_bytes = 16'h0010;
		i_packet_done = 1'b1;
		tick(1);
		chk(o_read_address, 24'h123466);
		tick(1);
		chk(o_read_address, 24'h123476);
		i_microframe_start = 1'b1;
		tick(1);
		i_microframe_start = 1'b0;
		i_packet_done = 1'b0;
		chk(o_read_address, 24'h123456);
		$display("test read address done");
	endtask

	// ----------------------------------------------------------------------------
	// Run control
	// ----------------------------------------------------------------------------
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// The tests need about two hundred cycles; the watchdog allows a hundred times that.
	initial begin
		repeat (20000) @(posedge i_clock);
		err_total++;
		$display("watchdog expired at %0t", $time);
		finish_test;
	end

	// Reset for 16 cycles, then the scenarios in order.
	initial begin
		repeat (16) @(posedge i_clock);
		#1;
		i_nrst = 1'b1;
		t_reset;
		t_masks;
		t_notify;
		t_tail_and_bell;
		t_counters;
		t_read_addr;
		finish_test;
	end
endmodule

// >>> touch_rx_dma_doorbell_notifier.sv
// Receive DMA doorbell notifier with work-queue tail update, counters and bulk address.
// Functional notes
// - Tail pointer low word writable bits 31:3
// - Tail pointer high word fully writable
// - Device writes tail value to pointed location
// - Item size held in bits 23:0
// - Queue size held in bits 23:0
// - Tail reset bit zeroes tail, self-clears
// - Enable bit runs flow on EOF non-header frames
// - Doorbell reset bit loads one, self-clears
// - Doorbell address low bits 31:2 only
// - Doorbell address high fully writable
// - Doorbell value resets one, loadable, incremented
// - Tail start value writable, resets zero
// - Bulk address restarts each microframe, advances
// - Read addresses limited to 24 bits
// - Doorbells counted in 31 bits, wrapping
// - Counter bit 31 write one clears count
// - All frames counted in 31 bits, wrapping
`timescale 1ns/1ns
`include "touch_rx_dma_regs.svh"
module touch_rx_dma_doorbell_notifier #(
	parameter int READ_ADDR_WIDTH = 24,
	parameter int PACKET_STEP_WIDTH = 16
) (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire touch_rx_dma_pkg::reg_req_s i_reg,
	input wire touch_rx_dma_pkg::frame_char_s i_frame,
	input wire logic i_microframe_start,
	input wire logic i_packet_done,
	input wire logic [PACKET_STEP_WIDTH-1:0] i_packet_bytes,
	input wire logic i_mem_ready,
	output logic [31:0] o_rdata,
	output logic o_rvalid,
	output touch_rx_dma_pkg::mem_wr_s o_mem,
	output logic [READ_ADDR_WIDTH-1:0] o_read_address,
	output logic o_notify_busy
);
	initial begin
		if (READ_ADDR_WIDTH != 24 || PACKET_STEP_WIDTH < 1 || PACKET_STEP_WIDTH > 24) begin
			$error("touch_rx_dma_doorbell_notifier: unsupported parameter values.");
		end
	end

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------
	// Doorbell successor; the value zero is never produced.
	function automatic logic [31:0] bell_next(input logic [31:0] v);
		logic [31:0] n;
		n = v + 32'h0000_0001;
		bell_next = (n == 32'h0000_0000) ? 32'h0000_0001 : n;
	endfunction

	// Wrapping 31-bit count increment.
	function automatic logic [30:0] count_next(input logic [30:0] v);
		count_next = v + 31'h0000_0001;
	endfunction

	function automatic logic wr_hit(input touch_rx_dma_pkg::reg_req_s r, input logic [15:0] a);
		wr_hit = r.wr && (r.addr == a);
	endfunction

	// ------------------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------------------
	logic [31:3] tail_ptr_low;
	logic [31:0] tail_ptr_high;
	logic [23:0] item_size;
	logic [23:0] queue_size;
	logic flow_enable;
	logic tail_reset_req;
	logic db_reset_req;
	logic [31:2] db_addr_low;
	logic [31:0] db_addr_high;
	logic [31:0] doorbell_value;
	logic [31:0] tail_start;
	logic [31:0] bulk_addr;
	logic [30:0] db_count;
	logic [30:0] frame_count;
	logic db_count_clear;
	logic frame_count_clear;
	logic [31:0] work_queue_tail;
	touch_rx_dma_pkg::notify_state_e state;
	logic [31:0] rdata;
	logic rvalid;
	touch_rx_dma_pkg::mem_wr_s mem;
	logic [23:0] read_addr;
	logic busy;

	logic [31:3] next_tail_ptr_low;
	logic [31:0] next_tail_ptr_high;
	logic [23:0] next_item_size;
	logic [23:0] next_queue_size;
	logic next_flow_enable;
	logic next_tail_reset_req;
	logic next_db_reset_req;
	logic [31:2] next_db_addr_low;
	logic [31:0] next_db_addr_high;
	logic [31:0] next_doorbell_value;
	logic [31:0] next_tail_start;
	logic [31:0] next_bulk_addr;
	logic [30:0] next_db_count;
	logic [30:0] next_frame_count;
	logic next_db_count_clear;
	logic next_frame_count_clear;
	logic [31:0] next_work_queue_tail;
	touch_rx_dma_pkg::notify_state_e next_state;
	logic [31:0] next_rdata;
	logic next_rvalid;
	touch_rx_dma_pkg::mem_wr_s next_mem;
	logic [23:0] next_read_addr;
	logic next_busy;

	logic qualify;
	logic bell_sent;
	logic [32:0] tail_sum;
	logic [31:0] tail_adv;

	assign qualify = i_frame.valid && i_frame.end_of_frame && !i_frame.frame_header_flag;
	assign bell_sent = (state == touch_rx_dma_pkg::ST_BELL) && mem.valid && i_mem_ready;
	// Tail advance; a zero queue size disables the wrap rather than dividing.
	assign tail_sum = {1'b0, work_queue_tail} + {9'h000, item_size};
	assign tail_adv = (queue_size != 24'h000000 && tail_sum >= {9'h000, queue_size}) ?
		tail_sum[31:0] - {8'h00, queue_size} : tail_sum[31:0];

	// ------------------------------------------------------------------------
	// Next-value logic
	// ------------------------------------------------------------------------
	// Software writes first, hardware updates after, so hardware events win.
	always_comb begin
		next_tail_ptr_low = tail_ptr_low;
		next_tail_ptr_high = tail_ptr_high;
		next_item_size = item_size;
		next_queue_size = queue_size;
		next_flow_enable = flow_enable;
		next_tail_reset_req = 1'b0;
		next_db_reset_req = 1'b0;
		next_db_addr_low = db_addr_low;
		next_db_addr_high = db_addr_high;
		next_doorbell_value = doorbell_value;
		next_tail_start = tail_start;
		next_bulk_addr = bulk_addr;
		next_db_count = db_count;
		next_frame_count = frame_count;
		next_db_count_clear = 1'b0;
		next_frame_count_clear = 1'b0;
		next_work_queue_tail = work_queue_tail;
		next_state = state;
		next_mem = mem;
		next_read_addr = read_addr;
		next_rvalid = i_reg.rd;
		next_rdata = 32'h0000_0000;
		if (wr_hit(i_reg, `OFF_TAIL_PTR_LOW)) begin
			next_tail_ptr_low = i_reg.wdata[31:`TAIL_LOW_LSB];
		end
		if (wr_hit(i_reg, `OFF_TAIL_PTR_HIGH)) begin
			next_tail_ptr_high = i_reg.wdata;
		end
		if (wr_hit(i_reg, `OFF_ITEM_SIZE)) begin
			next_item_size = i_reg.wdata[`SIZE_MSB:0];
		end
		if (wr_hit(i_reg, `OFF_QUEUE_SIZE)) begin
			next_queue_size = i_reg.wdata[`SIZE_MSB:0];
		end
		if (wr_hit(i_reg, `OFF_NOTIFY_CTRL)) begin
			next_flow_enable = i_reg.wdata[`BIT_FLOW_ENABLE];
			next_tail_reset_req = i_reg.wdata[`BIT_TAIL_RESET];
			next_db_reset_req = i_reg.wdata[`BIT_DB_RESET];
		end
		if (wr_hit(i_reg, `OFF_DB_ADDR_LOW)) begin
			next_db_addr_low = i_reg.wdata[31:`DB_LOW_LSB];
		end
		if (wr_hit(i_reg, `OFF_DB_ADDR_HIGH)) begin
			next_db_addr_high = i_reg.wdata;
		end
		if (wr_hit(i_reg, `OFF_DB_VALUE)) begin
			next_doorbell_value = i_reg.wdata;
		end
		if (wr_hit(i_reg, `OFF_TAIL_START)) begin
			next_tail_start = i_reg.wdata;
			next_work_queue_tail = i_reg.wdata;
		end
		if (wr_hit(i_reg, `OFF_BULK_ADDR)) begin
			next_bulk_addr = i_reg.wdata;
		end
		if (wr_hit(i_reg, `OFF_DB_COUNT)) begin
			next_db_count_clear = i_reg.wdata[`BIT_COUNT_CLEAR];
		end
		if (wr_hit(i_reg, `OFF_FRAME_COUNT)) begin
			next_frame_count_clear = i_reg.wdata[`BIT_COUNT_CLEAR];
		end
		// Pending reset requests act one cycle after the write and then drop.
		if (tail_reset_req) begin
			next_work_queue_tail = 32'h0000_0000;
		end
		if (db_reset_req) begin
			next_doorbell_value = `RST_DB_VALUE;
		end
		if (db_count_clear) begin
			next_db_count = 31'h0000_0000;
		end
		if (frame_count_clear) begin
			next_frame_count = 31'h0000_0000;
		end
		// Every frame counts, including ones that are not notified; a count with a pending clear leaves the count at one.
		if (i_frame.valid) begin
			next_frame_count = (frame_count_clear ? 31'h0000_0000 : frame_count) + 31'h0000_0001;
		end
		if (bell_sent) begin
			next_db_count = count_next(db_count_clear ? 31'h0000_0000 : db_count);
		end
		// Microframe start reloads the bulk address; packets step it within 24 bits.
		if (i_microframe_start) begin
			next_read_addr = bulk_addr[23:0];
		end else if (i_packet_done) begin
			next_read_addr = read_addr + {{(24-PACKET_STEP_WIDTH){1'b0}}, i_packet_bytes};
		end
		// Notification sequencer; frames arriving while busy are not queued.
		case (state)
			touch_rx_dma_pkg::ST_IDLE: begin
				if (flow_enable && qualify) begin
					next_work_queue_tail = tail_adv;
					next_state = touch_rx_dma_pkg::ST_TAIL;
					next_mem.valid = 1'b1;
					next_mem.addr = {tail_ptr_high, tail_ptr_low, 3'b000};
					next_mem.data = tail_adv;
				end
			end
			touch_rx_dma_pkg::ST_TAIL: begin
				if (i_mem_ready) begin
					next_state = touch_rx_dma_pkg::ST_BELL;
					next_mem.addr = {db_addr_high, db_addr_low, 2'b00};
					next_mem.data = doorbell_value;
				end
			end
			touch_rx_dma_pkg::ST_BELL: begin
				if (i_mem_ready) begin
					next_state = touch_rx_dma_pkg::ST_DONE;
					next_mem.valid = 1'b0;
					next_doorbell_value = bell_next(doorbell_value);
				end
			end
			touch_rx_dma_pkg::ST_DONE: begin
				next_state = touch_rx_dma_pkg::ST_IDLE;
			end
			default: begin
				next_state = touch_rx_dma_pkg::ST_IDLE;
				next_mem.valid = 1'b0;
			end
		endcase
		// Read data path; unmapped offsets read as zero.
		case (i_reg.addr)
			`OFF_TAIL_PTR_LOW: next_rdata = {tail_ptr_low, 3'b000};
			`OFF_TAIL_PTR_HIGH: next_rdata = tail_ptr_high;
			`OFF_ITEM_SIZE: next_rdata = {8'h00, item_size};
			`OFF_QUEUE_SIZE: next_rdata = {8'h00, queue_size};
			`OFF_NOTIFY_CTRL: next_rdata = {27'h0000000, tail_reset_req, flow_enable, db_reset_req, 2'b00};
			`OFF_DB_ADDR_LOW: next_rdata = {db_addr_low, 2'b00};
			`OFF_DB_ADDR_HIGH: next_rdata = db_addr_high;
			`OFF_DB_VALUE: next_rdata = doorbell_value;
			`OFF_TAIL_START: next_rdata = tail_start;
			`OFF_BULK_ADDR: next_rdata = bulk_addr;
			`OFF_DB_COUNT: next_rdata = {db_count_clear, db_count};
			`OFF_FRAME_COUNT: next_rdata = {frame_count_clear, frame_count};
			default: next_rdata = 32'h0000_0000;
		endcase
		if (!i_reg.rd) begin
			next_rdata = 32'h0000_0000;
		end
		// Busy is registered from the next state so the output comes from a flip-flop.
		next_busy = (next_state != touch_rx_dma_pkg::ST_IDLE);
	end

	// ------------------------------------------------------------------------
	// State registers
	// ------------------------------------------------------------------------
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			tail_ptr_low <= 29'h00000000;
			tail_ptr_high <= `RST_ZERO;
			item_size <= 24'h000000;
			queue_size <= 24'h000000;
			flow_enable <= 1'b0;
			tail_reset_req <= 1'b0;
			db_reset_req <= 1'b0;
			db_addr_low <= 30'h00000000;
			db_addr_high <= `RST_ZERO;
			doorbell_value <= `RST_DB_VALUE;
			tail_start <= `RST_ZERO;
			bulk_addr <= `RST_BULK_ADDR;
			db_count <= 31'h00000000;
			frame_count <= 31'h00000000;
			db_count_clear <= 1'b0;
			frame_count_clear <= 1'b0;
			work_queue_tail <= `RST_ZERO;
			state <= touch_rx_dma_pkg::ST_IDLE;
			rdata <= `RST_ZERO;
			rvalid <= 1'b0;
			mem <= '0;
			read_addr <= 24'h001000;
			busy <= 1'b0;
		end else begin
			tail_ptr_low <= next_tail_ptr_low;
			tail_ptr_high <= next_tail_ptr_high;
			item_size <= next_item_size;
			queue_size <= next_queue_size;
			flow_enable <= next_flow_enable;
			tail_reset_req <= next_tail_reset_req;
			db_reset_req <= next_db_reset_req;
			db_addr_low <= next_db_addr_low;
			db_addr_high <= next_db_addr_high;
			doorbell_value <= next_doorbell_value;
			tail_start <= next_tail_start;
			bulk_addr <= next_bulk_addr;
			db_count <= next_db_count;
			frame_count <= next_frame_count;
			db_count_clear <= next_db_count_clear;
			frame_count_clear <= next_frame_count_clear;
			work_queue_tail <= next_work_queue_tail;
			state <= next_state;
			rdata <= next_rdata;
			rvalid <= next_rvalid;
			mem <= next_mem;
			read_addr <= next_read_addr;
			busy <= next_busy;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign o_rdata = rdata;
	assign o_rvalid = rvalid;
	assign o_mem = mem;
	assign o_read_address = read_addr;
	assign o_notify_busy = busy;

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	sequence s_tail_write;
		mem.valid && (state == touch_rx_dma_pkg::ST_TAIL) && i_mem_ready;
	endsequence
	sequence s_bell_write;
		mem.valid && (state == touch_rx_dma_pkg::ST_BELL) && (mem.addr[1:0] == 2'b00);
	endsequence

	a_tail_then_bell: assert property (@(posedge i_clock) disable iff (!i_nrst) s_tail_write |=> s_bell_write)
		else $error("Doorbell write did not follow tail write.");
	a_tail_align: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(state == touch_rx_dma_pkg::ST_TAIL) |-> mem.addr[2:0] == 3'b000 && mem.valid)
		else $error("Tail write address not quadword aligned.");
	a_bell_nonzero: assert property (@(posedge i_clock) disable iff (!i_nrst) doorbell_value != 32'h0000_0000)
		else $error("Doorbell value became zero.");
	a_bell_reset_one: assert property (@(posedge i_clock) disable iff (!i_nrst)
		db_reset_req && !bell_sent |=> doorbell_value == 32'h0000_0001 && !db_reset_req)
		else $error("Doorbell reset did not load one.");
	a_tail_reset_zero: assert property (@(posedge i_clock) disable iff (!i_nrst)
		tail_reset_req && !(state == touch_rx_dma_pkg::ST_IDLE && flow_enable && qualify)
		&& !wr_hit(i_reg, `OFF_TAIL_START)
		|=> work_queue_tail == 32'h0000_0000)
		else $error("Tail reset did not clear tail.");
	a_flow_start: assert property (@(posedge i_clock) disable iff (!i_nrst)
		state == touch_rx_dma_pkg::ST_IDLE && flow_enable && qualify |=> state == touch_rx_dma_pkg::ST_TAIL)
		else $error("Qualifying frame did not start notification.");
	a_no_flow_off: assert property (@(posedge i_clock) disable iff (!i_nrst)
		state == touch_rx_dma_pkg::ST_IDLE && !(flow_enable && qualify) |=> !mem.valid)
		else $error("Notification started without qualifying frame.");
	a_bell_count: assert property (@(posedge i_clock) disable iff (!i_nrst)
		bell_sent && !db_count_clear |=> db_count == $past(db_count) + 31'h0000_0001)
		else $error("Doorbell count did not advance.");
	a_frame_count: assert property (@(posedge i_clock) disable iff (!i_nrst)
		i_frame.valid && !frame_count_clear |=> frame_count == $past(frame_count) + 31'h0000_0001)
		else $error("Frame count did not advance.");
	a_bulk_restart: assert property (@(posedge i_clock) disable iff (!i_nrst)
		i_microframe_start |=> read_addr == $past(bulk_addr[23:0]))
		else $error("Read address did not restart at bulk address.");
endmodule

// >>> touch_rx_dma_pkg.sv
// Types shared by the receive DMA notifier.
package touch_rx_dma_pkg;
	// Register bus request toward the block.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [31:0] wdata;
	} reg_req_s;
	// Memory write request toward the host memory fabric.
	typedef struct packed {
		logic valid;
		logic [63:0] addr;
		logic [31:0] data;
	} mem_wr_s;
	// Frame characteristics delivered when a frame has landed in memory.
	typedef struct packed {
		logic valid;
		logic end_of_frame;
		logic frame_header_flag;
	} frame_char_s;
	// Notification sequencer states.
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_TAIL = 4'b0010,
		ST_BELL = 4'b0100,
		ST_DONE = 4'b1000
	} notify_state_e;
endpackage

// >>> touch_rx_dma_regs.svh
// Register offsets, field positions, reset values and constants of the receive DMA notifier.
`ifndef TOUCH_RX_DMA_REGS_SVH
`define TOUCH_RX_DMA_REGS_SVH
// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFF_TAIL_PTR_LOW 16'h1118
`define OFF_TAIL_PTR_HIGH 16'h111C
`define OFF_ITEM_SIZE 16'h1120
`define OFF_QUEUE_SIZE 16'h1124
`define OFF_NOTIFY_CTRL 16'h1128
`define OFF_DB_ADDR_LOW 16'h1130
`define OFF_DB_ADDR_HIGH 16'h1134
`define OFF_DB_VALUE 16'h1138
`define OFF_TAIL_START 16'h1140
`define OFF_BULK_ADDR 16'h1170
`define OFF_DB_COUNT 16'h11A0
`define OFF_FRAME_COUNT 16'h11A4
// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define BIT_TAIL_RESET 4
`define BIT_FLOW_ENABLE 3
`define BIT_DB_RESET 2
`define BIT_COUNT_CLEAR 31
`define TAIL_LOW_LSB 3
`define DB_LOW_LSB 2
`define SIZE_MSB 23
`define RST_DB_VALUE 32'h0000_0001
`define RST_BULK_ADDR 32'h0000_1000
`define RST_ZERO 32'h0000_0000
`endif

// >>> work_queue_memory.sv
// Host memory model that takes the notifier's tail and doorbell writes.
`timescale 1ns/1ns
module work_queue_memory (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire touch_rx_dma_pkg::mem_wr_s i_mem,
	input wire logic i_slow,
	output logic o_ready
);
	logic [63:0] adr[$];
	logic [31:0] dat[$];
	int cnt;
	// ----------------------------------------------------------------------------
	// Acceptance
	// ----------------------------------------------------------------------------
	// Every accepted write is logged. In slow mode ready rises only after the request has waited,
	// so that a notifier which drops or changes its request early is caught.
	always @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			cnt <= 0;
			o_ready <= 1'b0;
		end else if (i_mem.valid && o_ready) begin
			adr.push_back(i_mem.addr);
			dat.push_back(i_mem.data);
			cnt <= 0;
			o_ready <= !i_slow;
		end else begin
			cnt <= i_mem.valid ? cnt + 1 : 0;
			o_ready <= !i_slow || (i_mem.valid && cnt >= 2);
		end
	end
endmodule
